// ---- hdl/pemc_host.sv ----
// Host controller driving the byte-wide EEPROM mode pins
`timescale 1ns/1ps
module pemc_host #(
  parameter int ERASE_CYC = pemc_pkg::ERASE_CYC,
  parameter int WRITE_CYC = pemc_pkg::WRITE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire pemc_pkg::pemc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [pemc_pkg::DATA_W-1:0] rsp_data,
  output pemc_pkg::pemc_pins_t pins,
  output logic [pemc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [pemc_pkg::DATA_W-1:0] dq_in
);
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_ACTIVE, S_SAMPLE, S_RECOVER, S_BUSY, S_GAP
  } pemc_state_t;

  pemc_state_t state;
  pemc_pkg::pemc_op_t op;
  logic [pemc_pkg::CNT_W-1:0] cnt;
  logic [pemc_pkg::DATA_W-1:0] dq_sync;
  logic [4:0] loaded;
  logic nv_op;

  pemc_sync #(.W(pemc_pkg::DATA_W)) u_sync (
    .clk(clk),
    .d(dq_in),
    .q(dq_sync)
  );

  assign nv_op = (op != pemc_pkg::PEMC_OP_READ) &&
                 (op != pemc_pkg::PEMC_OP_LOAD);

  // Sequencer: control lines settle, strobe, then timed waits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= pemc_pkg::PEMC_OP_READ;
      cnt <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                erase_path_control: 1'b1, program_path_control: 1'b1,
                addr: 12'h000};
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state)
        S_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            op <= req.op;
            pins.addr <= req.addr;
            dq_out <= req.data;
            cnt <= '0;
            // A write with nothing latched would commit no byte at all
            if (req.op == pemc_pkg::PEMC_OP_WRITE && loaded == 5'h00) begin
              state <= S_IDLE;
            end else begin
              state <= S_SETUP;
            end
            unique case (req.op)
              pemc_pkg::PEMC_OP_READ: begin
                pins.erase_path_control <= 1'b1;
                pins.program_path_control <= 1'b1;
              end
              pemc_pkg::PEMC_OP_CHIP_ERASE,
              pemc_pkg::PEMC_OP_PAGE_ERASE: begin
                pins.erase_path_control <= 1'b1;
                pins.program_path_control <= 1'b0;
              end
              pemc_pkg::PEMC_OP_LOAD: begin
                pins.erase_path_control <= 1'b0;
                pins.program_path_control <= 1'b0;
              end
              default: begin
                pins.erase_path_control <= 1'b0;
                pins.program_path_control <= 1'b1;
              end
            endcase
          end
        end
        // One cycle of control setup before the strobes fall
        S_SETUP: begin
          pins.cs_n <= 1'b0;
          cnt <= '0;
          state <= S_ACTIVE;
          unique case (op)
            pemc_pkg::PEMC_OP_READ,
            pemc_pkg::PEMC_OP_CHIP_ERASE: pins.oe_n <= 1'b0;
            pemc_pkg::PEMC_OP_LOAD: begin
              pins.we_n <= 1'b0;
              dq_oe <= 1'b1;
            end
            default: pins.we_n <= 1'b0;
          endcase
        end
        // Hold strobes; read waits access time plus synchroniser
        S_ACTIVE: begin
          cnt <= cnt + 1'b1;
          if (op == pemc_pkg::PEMC_OP_READ) begin
            if (cnt == pemc_pkg::CNT_W'(pemc_pkg::ACC_CYC + 2)) begin
              state <= S_SAMPLE;
            end
          end else if (cnt ==
                       pemc_pkg::CNT_W'(pemc_pkg::PULSE_CYC - 1)) begin
            pins.cs_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;
            cnt <= '0;
            state <= nv_op ? S_BUSY : S_RECOVER;
          end
        end
        S_SAMPLE: begin
          rsp_data <= dq_sync;
          rsp_valid <= 1'b1;
          pins.cs_n <= 1'b1;
          pins.oe_n <= 1'b1;
          cnt <= '0;
          state <= S_RECOVER;
        end
        // Release the bus, then keep lines for the short setup
        S_RECOVER: begin
          dq_oe <= 1'b0;
          cnt <= cnt + 1'b1;
          if (cnt == pemc_pkg::CNT_W'(pemc_pkg::SC_LR_CYC - 1)) begin
            state <= S_IDLE;
          end
        end
        // Self-timed operation: wait the longest device time
        S_BUSY: begin
          cnt <= cnt + 1'b1;
          if ((op == pemc_pkg::PEMC_OP_WRITE &&
               cnt == pemc_pkg::CNT_W'(WRITE_CYC - 1)) ||
              (op != pemc_pkg::PEMC_OP_WRITE &&
               cnt == pemc_pkg::CNT_W'(ERASE_CYC - 1))) begin
            cnt <= '0;
            state <= S_GAP;
          end
        end
        S_GAP: begin
          cnt <= cnt + 1'b1;
          if (cnt == pemc_pkg::CNT_W'(pemc_pkg::SC_EW_CYC - 1)) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Count latched bytes; an empty write is skipped, extra loads still go
  // out because the device simply overwrites a latch of the same page
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loaded <= 5'h00;
    end else if (state == S_IDLE && req_valid && req_ready) begin
      if (req.op == pemc_pkg::PEMC_OP_LOAD &&
          loaded != 5'(pemc_pkg::PAGE_BYTES)) begin
        loaded <= loaded + 5'h01;
      end else if (req.op == pemc_pkg::PEMC_OP_WRITE) begin
        loaded <= 5'h00;
      end
    end
  end
endmodule // pemc_host

// ---- hdl/pemc_sync.sv ----
// Two-stage synchroniser for the device data pins
`timescale 1ns/1ps
module pemc_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule // pemc_sync

// ---- shared/pemc_pkg.sv ----
// Constants and carrier types for the parallel EEPROM host controller
package pemc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 16;
  localparam int CLK_MHZ = 20;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  // Times as printed
  localparam int T_ACC_NS = 300;
  localparam int T_PULSE_NS = 200;
  localparam int T_REC_NS = 100;
  localparam int T_SC_LR_NS = 500;
  localparam int T_SC_EW_US = 50;
  localparam int T_ERASE_MS = 200;
  localparam int T_WRITE_MS = 20;
  // Least times round up
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SC_LR_CYC = (T_SC_LR_NS + CLK_NS - 1) / CLK_NS;
  localparam int SC_EW_CYC = T_SC_EW_US * CLK_MHZ;
  // Host must wait the longest device time
  localparam int ERASE_CYC = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int WRITE_CYC = T_WRITE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;

  typedef enum logic [2:0] {
    PEMC_OP_READ, PEMC_OP_CHIP_ERASE, PEMC_OP_PAGE_ERASE,
    PEMC_OP_LOAD, PEMC_OP_WRITE
  } pemc_op_t;

  typedef struct packed {
    pemc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pemc_req_t;

  // Pins toward the device; strobes active low
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic erase_path_control;
    logic program_path_control;
    logic [ADDR_W-1:0] addr;
  } pemc_pins_t;
endpackage

// ---- tb/pemc_dev.sv ----
// Behavioural byte-wide EEPROM facing the host
`timescale 1ns/1ps
module pemc_dev (
  input wire logic clk,
  input wire pemc_pkg::pemc_pins_t pins,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  output logic [7:0] dq_in
);
  logic [7:0] mem [4096];
  logic [7:0] lat [16];
  logic [15:0] lm = 16'h0;
  logic [7:0] pg, d, junk = 8'h0;
  logic [11:0] a;
  logic [3:0] op;
  logic act = 1'b0;
  wire rd = {pins.cs_n, pins.oe_n, pins.erase_path_control,
    pins.program_path_control} == 4'h3;
  // Released pins wander so a stale byte never passes
  always @(posedge clk) junk <= junk + 8'h3b;
  assign dq_in = rd ? (dq_oe ? 8'hxx : mem[pins.addr])
    : dq_oe ? dq_out : junk;
  // Latch at strobe start, act once select returns high
  always @(posedge clk) begin
    if (!pins.cs_n && !act) begin
      act <= 1'b1;
      op <= {pins.oe_n, pins.we_n, pins.erase_path_control,
        pins.program_path_control};
      a <= pins.addr;
      d <= dq_out;
    end
    if (pins.cs_n && act) begin
      act <= 1'b0;
      for (int i = 0; i < 4096; i++)
        if (op == 4'h6 || (op == 4'ha && i[11:4] == a[11:4]))
          mem[i] <= 8'h0;
      if (op == 4'h8) begin
        lat[a[3:0]] <= d;
        lm[a[3:0]] <= 1'b1;
        pg <= a[11:4];
      end
      if (op == 4'h9) begin
        for (int i = 0; i < 16; i++)
          if (lm[i])
            mem[{pg, i[3:0]}] <= mem[{pg, i[3:0]}] | lat[i];
        lm <= 16'h0;
      end
    end
  end
endmodule // pemc_dev

// ---- tb/pemc_host_asserts.sv ----
// Port checks for the EEPROM host controller
`timescale 1ns/1ps
module pemc_host_asserts #(
  parameter int ERASE_CYC = pemc_pkg::ERASE_CYC,
  parameter int WRITE_CYC = pemc_pkg::WRITE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire pemc_pkg::pemc_pins_t pins,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Strobes, then the erase and program lines
  wire [3:0] md = {pins.oe_n, pins.we_n,
    pins.erase_path_control, pins.program_path_control};
  sequence s_st; !pins.cs_n && !pins.we_n; endsequence
  chk_mode_ok: assert property (
    !pins.cs_n |-> md inside {4'h7, 4'h6, 4'ha, 4'h8, 4'h9})
    else $error("bad mode");
  chk_we_width: assert property (
    $fell(pins.we_n) |-> s_st [*4]) else $error("we width");
  chk_load_hold: assert property (
    s_st ##1 s_st |-> $stable(pins.addr) && $stable(dq_out))
    else $error("hold");
  chk_load_drv: assert property (
    !pins.cs_n && md == 4'h8 |-> dq_oe) else $error("load drive");
  chk_no_clash: assert property (
    dq_oe |-> pins.oe_n) else $error("clash");
  chk_read_rsp: assert property (
    rsp_valid |-> $past(md == 4'h7 && !pins.cs_n)) else $error("rsp");
  chk_read_span: assert property (
    $fell(pins.oe_n) && md[1:0] == 2'h3 |-> !pins.oe_n [*6])
    else $error("oe width");
  chk_idle_quiet: assert property (
    req_ready |-> pins.cs_n && !dq_oe) else $error("idle");
  localparam int SC_LR = pemc_pkg::SC_LR_CYC;
  localparam int SC_EW = pemc_pkg::SC_EW_CYC;
  // Cycles since the strobes last rose, and the mode lines they carried
  int unsigned since_rel;
  logic cs_q;
  logic [1:0] ctl_q, last_ctl;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_rel <= 32'h00ff_ffff;
      cs_q <= 1'b1;
      ctl_q <= 2'h3;
      last_ctl <= 2'h3;
    end else begin
      cs_q <= pins.cs_n;
      ctl_q <= md[1:0];
      if (pins.cs_n && !cs_q) begin
        since_rel <= 32'h0000_0001;
        last_ctl <= ctl_q;
      end else if (since_rel < 32'h00ff_ffff) begin
        since_rel <= since_rel + 32'h0000_0001;
      end
    end
  end
  chk_erase_wait: assert property (
    $rose(req_ready) && last_ctl == 2'h2 |-> since_rel > ERASE_CYC + SC_EW)
    else $error("erase wait");
  chk_write_wait: assert property (
    $rose(req_ready) && last_ctl == 2'h1 |-> since_rel > WRITE_CYC + SC_EW)
    else $error("write wait");
  chk_ctl_setup: assert property (
    $changed(md[1:0]) |-> since_rel > SC_LR) else $error("control setup");
endmodule // pemc_host_asserts

// ---- tb/testbench.sv ----
// Self-checking bench for the EEPROM host controller
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
  pemc_pkg::pemc_req_t req = '0;
  logic req_ready, rsp_valid, dq_oe;
  logic [7:0] rsp_data, dq_out, dq_in, pd;
  pemc_pkg::pemc_pins_t pins;
  logic [7:0] em [4096];
  logic [7:0] q [$];
  logic [11:0] pa;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  always #25 clk = ~clk;
  pemc_host #(.ERASE_CYC(20), .WRITE_CYC(10)) u_dut (.clk(clk),
    .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  pemc_dev u_mem (.clk(clk), .pins(pins), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in));
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Offered at a falling edge, held until the edge that takes it
  task automatic go(input logic [2:0] op, input logic [11:0] a,
    input logic [7:0] d);
    while (req_ready !== 1'b1) @(negedge clk);
    req_valid = 1'b1;
    req = '{pemc_pkg::pemc_op_t'(op), a, d};
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    q.push_back(em[a]);
    go(3'h0, a, 8'($urandom));
  endtask
  // Each answer takes the oldest expectation; a hang ends the run
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (rsp_valid === 1'b1) begin
      checks_done++;
      if (q.size() == 0 || rsp_data !== q.pop_front()) begin
        error_cnt++;
        $display("ERROR %0t read data", $time);
      end
    end
    if (cyc == 20000) begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  end
  initial begin
    void'($urandom(32'hce2e));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    go(3'h1, 12'($urandom), 8'($urandom));
    for (int i = 0; i < 4096; i++) em[i] = 8'h0;
    pa = {8'($urandom), 4'h0};
    // Full page loaded top down, then one byte on the next page
    for (int i = 15; i >= 0; i--) begin
      pd = 8'($urandom);
      em[pa + 12'(i)] = pd;
      go(3'h3, pa + 12'(i), pd);
    end
    go(3'h4, 12'($urandom), 8'($urandom));
    go(3'h3, pa + 12'h10, 8'ha5);
    go(3'h4, 12'h0, 8'h0);
    go(3'h4, 12'h0, 8'h0);
    em[pa + 12'h10] = 8'ha5;
    for (int i = -1; i < 18; i++) rd(pa + 12'(i));
    go(3'h2, pa + 12'h7, 8'($urandom));
    for (int i = 0; i < 16; i++) em[pa + 12'(i)] = 8'h0;
    for (int i = 0; i < 18; i++) rd(pa + 12'(i));
    while (q.size() != 0) @(negedge clk);
    final_report();
  end
endmodule // testbench
bind pemc_host pemc_host_asserts #(.ERASE_CYC(ERASE_CYC),
  .WRITE_CYC(WRITE_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins),
  .dq_out(dq_out), .dq_oe(dq_oe));
